// *** rtl/rps_pkg.sv ***
/*
  Constants shared by the remappable pin select block: sizes, register
  indices, field positions, reset values and unlock keys.
  Assumes a single 50 MHz clock and a plain strobe register port.
*/
// Function
// [R1] Bidirectional pins take routed inputs and outputs
// [R2] Input-only pins never drive routed outputs
// [R3] Routed peripherals reach no pin until assigned
// [R4] Fixed peripherals sit on their default pin
// [R5] Routed peripheral beats gpio and fixed functions
// [R6] Analog function always beats routed peripheral
// [R7] Input and output routing in separate registers
// [R8] Lock and key sequence guard the mapping
// [R9] Serial bus and motor PWM use fixed pins
// [R10] Input fields seven bits, zero ties low
// [R11] Unimplemented bits read zero, writes ignored
`default_nettype none

package rps_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned N_BIDIR = 8;
  localparam int unsigned N_IN_ONLY = 8;
  localparam int unsigned N_PER_IN = 8;
  localparam int unsigned N_PER_OUT = 8;
  localparam int unsigned ISEL_W = 7;
  localparam int unsigned OSEL_W = 6;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;

  // ==========================================================
  // Input select codes
  localparam logic [6:0] ISEL_TIE_LOW = 7'h00;
  localparam logic [6:0] ISEL_BIDIR_FIRST = 7'h01;
  localparam logic [6:0] ISEL_IN_ONLY_FIRST = 7'h09;
  localparam logic [6:0] ISEL_LAST = 7'h10;

  // Output select codes: zero leaves the pin to other users
  localparam logic [5:0] OSEL_NONE = 6'h00;
  localparam logic [5:0] OSEL_FIRST = 6'h01;
  localparam logic [5:0] OSEL_LAST = 6'h08;

  // ==========================================================
  // Register indices
  localparam logic [3:0] REG_IN_SEL0 = 4'h0;
  localparam logic [3:0] REG_IN_SEL1 = 4'h1;
  localparam logic [3:0] REG_IN_SEL2 = 4'h2;
  localparam logic [3:0] REG_DEADTIME_CMP_IN_SEL = 4'h3;
  localparam logic [3:0] REG_OUT_SEL0 = 4'h4;
  localparam logic [3:0] REG_OUT_SEL3 = 4'h7;
  localparam logic [3:0] REG_LOCK_CTL = 4'h8;
  localparam logic [3:0] REG_KEY = 4'h9;
  localparam logic [3:0] REG_STATUS = 4'ha;

  // ==========================================================
  // Field positions
  localparam int unsigned FLD_LO_LSB = 0;
  localparam int unsigned FLD_HI_LSB = 8;
  localparam int unsigned LOCK_BIT = 0;
  localparam int unsigned STAT_LOCK_BIT = 0;
  localparam int unsigned STAT_ARMED_BIT = 1;
  localparam int unsigned STAT_VIOL_BIT = 2;

  // ==========================================================
  // Reset values and keys
  localparam logic [6:0] ISEL_RESET = 7'h00;
  localparam logic [5:0] OSEL_RESET = 6'h00;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic [15:0] KEY_FIRST = 16'h0055;
  localparam logic [15:0] KEY_SECOND = 16'h00aa;

endpackage : rps_pkg

`default_nettype wire

// *** rtl/rps_in_sel.sv ***
/*
  One routed peripheral input: picks a pin by its seven-bit code.
  Assumes pin levels are synchronous to clk_sys.
*/
`default_nettype none

module rps_in_sel (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [6:0] sel, // Input select code
  input wire logic [7:0] bidir_in, // Bidirectional pin levels
  input wire logic [7:0] in_only_in, // Input-only pin levels
  input wire logic [7:0] bidir_analog, // Bidirectional pins in analog
  input wire logic [7:0] in_only_analog, // Input-only pins in analog
  output logic periph_in // Routed level to the peripheral
);

  logic [6:0] idx_b;
  logic [6:0] idx_i;
  logic periph_in_next;

  assign idx_b = sel - rps_pkg::ISEL_BIDIR_FIRST;
  assign idx_i = sel - rps_pkg::ISEL_IN_ONLY_FIRST;

  // Analog pins read low on the digital side
  always_comb begin
    periph_in_next = 1'b0; // see [R10]
    if (sel >= rps_pkg::ISEL_IN_ONLY_FIRST && sel <= rps_pkg::ISEL_LAST) begin
      periph_in_next = in_only_in[idx_i[2:0]] &
                       ~in_only_analog[idx_i[2:0]]; // see [R1] see [R6]
    end else if (sel >= rps_pkg::ISEL_BIDIR_FIRST) begin
      if (sel < rps_pkg::ISEL_IN_ONLY_FIRST) begin
        periph_in_next = bidir_in[idx_b[2:0]] & ~bidir_analog[idx_b[2:0]];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      periph_in <= 1'b0;
    end else begin
      periph_in <= periph_in_next;
    end
  end

endmodule // rps_in_sel

`default_nettype wire

// *** rtl/rps_pin_drive.sv ***
/*
  Output priority for one bidirectional pin.
  Assumes peripheral and gpio drive requests are synchronous to clk_sys.
*/
`default_nettype none

module rps_pin_drive (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [5:0] osel, // Output select code
  input wire logic [7:0] per_out, // Routed peripheral output levels
  input wire logic [7:0] per_oe, // Routed peripheral drive requests
  input wire logic [7:0] per_active, // Routed peripheral enabled
  input wire logic fixed_en, // Fixed-pin peripheral active
  input wire logic fixed_out, // Fixed-pin peripheral level
  input wire logic fixed_oe, // Fixed-pin peripheral drive request
  input wire logic gpio_out, // General I/O level
  input wire logic gpio_oe, // General I/O drive request
  input wire logic analog_en, // Pin given to an analog function
  output logic pin_out, // Pin output level
  output logic pin_oe // Pin output enable, high drives
);

  logic [5:0] idx;
  logic routed;
  logic pin_out_next;
  logic pin_oe_next;

  assign idx = osel - rps_pkg::OSEL_FIRST;
  assign routed = (osel >= rps_pkg::OSEL_FIRST) &&
                  (osel <= rps_pkg::OSEL_LAST) &&
                  per_active[idx[2:0]]; // see [R3]

  always_comb begin
    pin_out_next = gpio_out;
    pin_oe_next = gpio_oe;
    if (analog_en) begin
      pin_out_next = 1'b0; // see [R6]
      pin_oe_next = 1'b0;
    end else if (routed) begin
      pin_out_next = per_out[idx[2:0]]; // see [R5]
      pin_oe_next = per_oe[idx[2:0]];
    end else if (fixed_en) begin
      pin_out_next = fixed_out; // see [R4] see [R9]
      pin_oe_next = fixed_oe;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= pin_out_next;
      pin_oe <= pin_oe_next;
    end
  end

endmodule // rps_pin_drive

`default_nettype wire

// *** rtl/rps_top.sv ***
/*
  Remappable pin select: routing registers, write guard, input
  selectors for each routed peripheral input and priority drivers
  for each bidirectional pin.
  Assumes a plain strobe register port on clk_sys, one strobe at a time,
  and peripherals and pins synchronous to clk_sys.
*/
`default_nettype none

module rps_top (
  input wire logic clk_sys, // System clock, 50 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  // Register port
  input wire logic [3:0] reg_addr, // Register index
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, cycle after strobe
  // Remappable pins
  input wire logic [7:0] bidir_remap_pin_in, // Bidirectional pin levels
  output logic [7:0] bidir_remap_pin_out, // Bidirectional pin drive
  output logic [7:0] bidir_remap_pin_oe, // High while pin is driven
  input wire logic [7:0] input_only_remap_pin_in, // Input-only pins
  input wire logic [7:0] bidir_analog_en, // Analog owns bidir pin
  input wire logic [7:0] in_only_analog_en, // Analog owns input pin
  // Peripheral side
  output logic [7:0] per_in, // Routed inputs to peripherals
  input wire logic [7:0] per_out, // Peripheral output levels
  input wire logic [7:0] per_oe, // Peripheral drive requests
  input wire logic [7:0] per_active, // Peripheral enabled
  input wire logic [7:0] fixed_en, // Fixed-pin function active per pin
  input wire logic [7:0] fixed_out, // Fixed-pin function levels
  input wire logic [7:0] fixed_oe, // Fixed-pin function drive requests
  output logic [7:0] fixed_in, // Pin levels to fixed functions
  input wire logic [7:0] gpio_out, // General I/O levels
  input wire logic [7:0] gpio_oe, // General I/O drive requests
  output logic mapping_locked // Routing registers write-protected
);

  // ==========================================================
  // Routing registers
  logic [6:0] in_sel_reg [8];
  logic [5:0] out_sel_reg [8];
  logic lock_reg;
  logic armed_reg;
  logic viol_reg;
  logic [15:0] rdata_next;
  logic wr_in;
  logic wr_out;
  logic wr_route;
  logic unlock;
  logic [2:0] in_base;
  logic [2:0] out_base;

  assign wr_in = reg_wr && (reg_addr <= rps_pkg::REG_DEADTIME_CMP_IN_SEL);
  assign wr_out = reg_wr && (reg_addr >= rps_pkg::REG_OUT_SEL0) &&
                  (reg_addr <= rps_pkg::REG_OUT_SEL3);
  assign wr_route = wr_in || wr_out;
  assign unlock = reg_wr && (reg_addr == rps_pkg::REG_KEY) && armed_reg &&
                  (reg_wdata == rps_pkg::KEY_SECOND);
  // Each register holds two fields: low at even, high at odd entry
  assign in_base = {reg_addr[1:0], 1'b0};
  assign out_base = {reg_addr[1:0], 1'b0};

  // Input routing; the last pair is the deadtime compare selects,
  // cmp2 in the low field and cmp3 in the high field
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        in_sel_reg[i] <= rps_pkg::ISEL_RESET; // see [R10] see [R3]
      end
    end else if (wr_in && !lock_reg) begin // see [R7] see [R8]
      in_sel_reg[in_base] <=
        reg_wdata[rps_pkg::FLD_LO_LSB +: 7]; // see [R11]
      in_sel_reg[in_base + 3'd1] <= reg_wdata[rps_pkg::FLD_HI_LSB +: 7];
    end
  end

  // Output routing
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        out_sel_reg[i] <= rps_pkg::OSEL_RESET; // see [R3]
      end
    end else if (wr_out && !lock_reg) begin // see [R7] see [R8]
      out_sel_reg[out_base] <= reg_wdata[rps_pkg::FLD_LO_LSB +: 6];
      out_sel_reg[out_base + 3'd1] <= reg_wdata[rps_pkg::FLD_HI_LSB +: 6];
    end
  end

  // ==========================================================
  // Write guard
  // Locking is one write; unlocking needs both keys back to back on
  // the key register, so a stray write cannot reopen the mapping.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lock_reg <= rps_pkg::LOCK_RESET;
    end else if (unlock) begin
      lock_reg <= 1'b0; // see [R8]
    end else if (reg_wr && reg_addr == rps_pkg::REG_LOCK_CTL &&
                 reg_wdata[rps_pkg::LOCK_BIT]) begin
      lock_reg <= 1'b1;
    end
  end

  // Any other write between the keys disarms the sequence
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      armed_reg <= 1'b0;
    end else if (reg_wr) begin
      armed_reg <= (reg_addr == rps_pkg::REG_KEY) &&
                   (reg_wdata == rps_pkg::KEY_FIRST); // see [R8]
    end
  end

  // Sticky flag of refused routing writes; a new refusal beats the clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      viol_reg <= 1'b0;
    end else if (wr_route && lock_reg) begin
      viol_reg <= 1'b1; // see [R8]
    end else if (reg_wr && reg_addr == rps_pkg::REG_STATUS &&
                 reg_wdata[rps_pkg::STAT_VIOL_BIT]) begin
      viol_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mapping_locked <= 1'b0;
    end else begin
      mapping_locked <= lock_reg;
    end
  end

  // ==========================================================
  // Read back
  always_comb begin
    rdata_next = 16'h0000; // see [R11]
    if (reg_addr <= rps_pkg::REG_DEADTIME_CMP_IN_SEL) begin
      rdata_next[rps_pkg::FLD_LO_LSB +: 7] = in_sel_reg[in_base];
      rdata_next[rps_pkg::FLD_HI_LSB +: 7] = in_sel_reg[in_base + 3'd1];
    end else if (reg_addr <= rps_pkg::REG_OUT_SEL3) begin
      rdata_next[rps_pkg::FLD_LO_LSB +: 6] = out_sel_reg[out_base];
      rdata_next[rps_pkg::FLD_HI_LSB +: 6] = out_sel_reg[out_base + 3'd1];
    end else if (reg_addr == rps_pkg::REG_LOCK_CTL) begin
      rdata_next[rps_pkg::LOCK_BIT] = lock_reg;
    end else if (reg_addr == rps_pkg::REG_STATUS) begin
      rdata_next[rps_pkg::STAT_LOCK_BIT] = lock_reg;
      rdata_next[rps_pkg::STAT_ARMED_BIT] = armed_reg;
      rdata_next[rps_pkg::STAT_VIOL_BIT] = viol_reg;
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ==========================================================
  // Fixed-function inputs see their pin directly, analog reads low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fixed_in <= 8'h00;
    end else begin
      fixed_in <= bidir_remap_pin_in & ~bidir_analog_en; // see [R9]
    end
  end

  // ==========================================================
  // Routing network
  // Input-only pins appear only in the input selectors; they have no
  // driver at all, so no code can make them drive.
  for (genvar g = 0; g < 8; g++) begin : g_in
    rps_in_sel u_in_sel (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .sel(in_sel_reg[g]),
      .bidir_in(bidir_remap_pin_in),
      .in_only_in(input_only_remap_pin_in), // see [R2]
      .bidir_analog(bidir_analog_en),
      .in_only_analog(in_only_analog_en),
      .periph_in(per_in[g])
    );
  end

  for (genvar g = 0; g < 8; g++) begin : g_pin
    rps_pin_drive u_pin_drive (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .osel(out_sel_reg[g]),
      .per_out(per_out),
      .per_oe(per_oe),
      .per_active(per_active),
      .fixed_en(fixed_en[g]),
      .fixed_out(fixed_out[g]),
      .fixed_oe(fixed_oe[g]),
      .gpio_out(gpio_out[g]),
      .gpio_oe(gpio_oe[g]),
      .analog_en(bidir_analog_en[g]),
      .pin_out(bidir_remap_pin_out[g]), // see [R1]
      .pin_oe(bidir_remap_pin_oe[g])
    );
  end

endmodule // rps_top

`default_nettype wire

// *** bench/rps_chk.sv ***
/* Assertions on the ports of the pin select top.
   Assumes one clock domain, bound to every rps_top instance. */
`default_nettype none
module rps_chk (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic [3:0] reg_addr, // Register index
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic [7:0] bidir_remap_pin_in, // Pin levels
  input wire logic [7:0] bidir_remap_pin_oe, // Pin drive enables
  input wire logic [7:0] bidir_analog_en, // Analog owns pin
  input wire logic [7:0] per_active, // Peripheral enabled
  input wire logic [7:0] fixed_en, // Fixed function active
  input wire logic [7:0] fixed_oe, // Fixed function drive
  input wire logic [7:0] fixed_in, // Pin levels to fixed functions
  input wire logic [7:0] gpio_oe, // General I/O drive
  input wire logic mapping_locked // Write protection
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Sequences
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence lock_wr;
    reg_wr && reg_addr == 4'h8 && reg_wdata[0];
  endsequence
  sequence key_pair;
    reg_wr && reg_addr == 4'h9 && reg_wdata == 16'h0055 ##1
    reg_wr && reg_addr == 4'h9 && reg_wdata == 16'h00aa;
  endsequence
  sequence refused_then_status;
    reg_wr && reg_addr < 4'h8 ##1
    mapping_locked && reg_rd && reg_addr == 4'ha;
  endsequence
  // ==========================================================
  // Properties
  rd_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read slot");
  unmapped_zero_a: assert property (
    $past(reg_rd) && $past(reg_addr) > 4'ha |-> reg_rdata == 16'h0000)
    else $error("unmapped register read not zero");
  sel_holes_a: assert property (
    $past(reg_rd) && $past(reg_addr) < 4'h4
    |-> (reg_rdata & 16'h8080) == 16'h0000)
    else $error("input select hole bits not zero");
  lock_set_a: assert property (
    lock_wr |-> ##2 mapping_locked)
    else $error("lock write did not protect mapping");
  unlock_a: assert property (
    key_pair |-> ##2 !mapping_locked)
    else $error("key pair did not unlock mapping");
  refused_flag_a: assert property (
    refused_then_status |-> ##1 reg_rdata[2])
    else $error("refused write not flagged");
  status_lock_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 4'ha
    |-> reg_rdata[0] == mapping_locked)
    else $error("status lock bit disagrees with lock output");
  analog_wins_a: assert property (
    ($past(bidir_analog_en) & bidir_remap_pin_oe) == 8'h00)
    else $error("analog pin driven");
  fixed_in_a: assert property (
    !$past(sys_rst) |->
    fixed_in == $past(bidir_remap_pin_in & ~bidir_analog_en))
    else $error("fixed input level wrong");
  prio_a: assert property (
    !$past(sys_rst) && $past(per_active) == 8'h00
    |-> bidir_remap_pin_oe == $past(((fixed_en & fixed_oe) |
    (~fixed_en & gpio_oe)) & ~bidir_analog_en))
    else $error("pin drive priority wrong");
endmodule // rps_chk
bind rps_top rps_chk i_rps_chk (.clk_sys, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .bidir_remap_pin_in, .bidir_remap_pin_oe,
  .bidir_analog_en, .per_active, .fixed_en, .fixed_oe, .fixed_in, .gpio_oe,
  .mapping_locked);
`default_nettype wire

// *** bench/rps_periph_model.sv ***
/* Routed peripherals on the far side: output levels and drive requests.
   Assumes clk_sys; the pattern moves each cycle so stale drives show. */
`default_nettype none
module rps_periph_model (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset
  output logic [7:0] per_out, // Peripheral output levels
  output logic [7:0] per_oe // Peripheral drive requests
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pat_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      pat_reg <= 8'h5a;
    else
      pat_reg <= {pat_reg[6:0], ^(pat_reg & 8'hb8)};
  end
  assign per_out = pat_reg;
  assign per_oe = {pat_reg[3:0], pat_reg[7:4]} ^ 8'h0f;
endmodule // rps_periph_model
`default_nettype wire

// *** bench/tb_top.sv ***
/* Self-checking bench for the pin select top.
   Assumes the checker binds itself and the peripheral model sits beside. */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string nm; logic [15:0] exp; int k;} rps_note_s;
  logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic rd_seen = 1'b0, locked;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [7:0] b_in = 8'h00, i_in = 8'h00, b_an = 8'h00, i_an = 8'h00;
  logic [7:0] p_act = 8'h00, f_en = 8'h00, f_out = 8'h00, f_oe = 8'h00;
  logic [7:0] g_out = 8'h00, g_oe = 8'h00;
  logic [7:0] b_out, b_oe, per_in, per_out, per_oe, f_in;
  logic [31:0] seed = 32'h066f2658;
  rps_note_s q_rd[$], q_pin[$];
  int n_mismatch = 0, checks_done = 0, cycles = 0;
  always #10 clk_sys = ~clk_sys;
  rps_top i_rps_top (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .bidir_remap_pin_in(b_in),
    .bidir_remap_pin_out(b_out), .bidir_remap_pin_oe(b_oe),
    .input_only_remap_pin_in(i_in), .bidir_analog_en(b_an),
    .in_only_analog_en(i_an), .per_in, .per_out, .per_oe,
    .per_active(p_act), .fixed_en(f_en), .fixed_out(f_out),
    .fixed_oe(f_oe), .fixed_in(f_in), .gpio_out(g_out), .gpio_oe(g_oe),
    .mapping_locked(locked));
  rps_periph_model i_rps_periph_model (.clk_sys, .sys_rst, .per_out,
    .per_oe);
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rps_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Strobes stay up until the next task sets them, so no signal is
  // assigned twice in one time step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    q_rd.push_back('{$sformatf("reg %h", a), e, 0});
    @(posedge clk_sys);
  endtask
  task automatic pin_round(input int k);
    logic [7:0] eo, ev, ei;
    wr(4'h3, {1'b0, 7'(9 + k), 1'b0, 7'(1 + k)});
    reg_wr <= 1'b0;
    repeat (3) begin
      seed = rps_lfsr(seed);
      {b_in, i_in, f_out, g_out} <= seed;
      seed = rps_lfsr(seed);
      {p_act, f_en, f_oe, g_oe} <= seed;
      b_an <= seed[7:0] & seed[15:8];
      i_an <= seed[23:16] & seed[31:24];
      @(negedge clk_sys);
      ei = {i_in[k] & ~i_an[k], b_in[k] & ~b_an[k], 6'h00};
      for (int p = 0; p < 8; p++) begin
        if (p % 2 == 0 && p_act[p + 1])
          {eo[p], ev[p]} = {per_oe[p + 1], per_out[p + 1]};
        else if (f_en[p])
          {eo[p], ev[p]} = {f_oe[p], f_out[p]};
        else
          {eo[p], ev[p]} = {g_oe[p], g_out[p]};
      end
      eo = eo & ~b_an;
      q_pin.push_back('{"routed inputs", {8'h00, ei}, 0});
      q_pin.push_back('{"pin enables", {8'h00, eo}, 1});
      q_pin.push_back('{"pin levels", {8'h00, ev & eo}, 2});
      @(posedge clk_sys);
    end
  endtask
  // ==========================================================
  // Monitors
  always @(posedge clk_sys) rd_seen <= reg_rd;
  always @(negedge clk_sys) begin : mon_rd
    rps_note_s n;
    if (rd_seen && q_rd.size() > 0) begin
      n = q_rd.pop_front();
      chk(n.nm, reg_rdata, n.exp);
    end
  end
  always @(posedge clk_sys) begin : mon_pin
    rps_note_s n;
    #1;
    while (q_pin.size() > 0) begin
      n = q_pin.pop_front();
      case (n.k)
        0: chk(n.nm, {8'h00, per_in}, n.exp);
        1: chk(n.nm, {8'h00, b_oe}, n.exp);
        default: chk(n.nm, {8'h00, b_out & b_oe}, n.exp);
      endcase
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // ==========================================================
  // Sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int a = 0; a < 16; a++)
      rd(4'(a), 16'h0000);
    wr(4'h3, 16'hffff);
    rd(4'h3, 16'h7f7f);
    wr(4'h4, 16'hffff);
    rd(4'h4, 16'h3f3f);
    // Even pins take peripheral outputs 1, 3, 5, 7; odd pins stay free
    for (int m = 0; m < 4; m++)
      wr(4'(4 + m), 16'(2 * m + 2));
    for (int k = 0; k < 8; k++)
      pin_round(k);
    wr(4'h8, 16'h0001);
    wr(4'h0, 16'h0505);
    rd(4'ha, 16'h0005);
    rd(4'h0, 16'h0000);
    wr(4'h9, 16'h0055);
    wr(4'h9, 16'h00aa);
    wr(4'ha, 16'h0004);
    wr(4'h0, 16'h0505);
    rd(4'ha, 16'h0000);
    rd(4'h0, 16'h0505);
    reg_rd <= 1'b0;
    repeat (3) @(posedge clk_sys);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
